// File: rtl/qdr_ctrl.sv
// Top: command decode, reference mode, channel state and APB registers
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/10ps
module qdr_ctrl
    import qdr_pkg::*;
#(
    parameter int SYNC_STAGES = 2
)
(
    // System
    input wire logic clk,
    input wire logic rst_b,
    // Serial link
    input wire logic sclk,
    input wire logic sync_b,
    input wire logic din,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Converter controls
    output logic [NCH-1:0][CODE_W-1:0] chan_code,
    output logic [NCH-1:0] chan_pd,
    output logic [2*NCH-1:0] chan_pd_mode,
    output logic ref_on,
    output logic [2:0] ref_mode
);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [SYNC_STAGES-1:0] tgl_sync;
        logic tgl_seen;
        qdr_ref_mode_type mode;
        logic [NCH-1:0][CODE_W-1:0] code;
        logic [NCH-1:0] pd;
        logic [2*NCH-1:0] pdm;
        logic ref_on;
        logic link_en;
        logic [7:0] cmd_cnt;
        logic [CMD_W-1:0] last_cmd;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } qdr_state_type;

    qdr_state_type s_r;
    qdr_state_type s_nxt;

    qdr_link_if lnk ();

    // ---------------------------------------------------------------
    // Link receiver
    // ---------------------------------------------------------------
    qdr_serial_rx u_rx (
        .sclk(sclk),
        .rst_b(rst_b),
        .sync_b(sync_b),
        .din(din),
        .lnk(lnk.rx)
    );

    // ---------------------------------------------------------------
    // Command decode
    // ---------------------------------------------------------------
    function automatic qdr_state_type apply_cmd(input qdr_state_type s,
                                                input logic [CMD_W-1:0] w);
        qdr_state_type n;
        logic [1:0] ld;
        logic [1:0] sel;
        logic pdf;
        logic [CODE_W-1:0] code;
        logic [1:0] pdm;
        logic [3:0] rc;
        n = s;
        ld = {w[LDH_BIT], w[LDL_BIT]};
        sel = w[SEL_HI:SEL_LO];
        pdf = w[PDF_BIT];
        code = w[CODE_HI:CODE_LO];
        pdm = w[PDM_HI:PDM_LO];
        rc = w[REF_HI:REF_LO];
        if (ld == LD_NONE && sel == SEL_NONE && pdf) begin
            // Unlisted reference patterns are buffer-only writes: no effect
            case (rc)
                REF_CMD_OFF: n.mode = REF_OFF;
                REF_CMD_AUTO: n.mode = REF_AUTO;
                REF_CMD_ON: n.mode = REF_ON;
                default: n.mode = s.mode;
            endcase
        end else if (ld == LD_BCAST && sel == SEL_BCAST) begin
            for (int i = 0; i < NCH; i++) begin
                if (!pdf) begin
                    n.code[i] = code;
                    n.pd[i] = 1'b0;
                    n.pdm[2*i +: 2] = PDM_RUN;
                end else if (pdm != PDM_RUN) begin
                    n.pd[i] = 1'b1;
                    n.pdm[2*i +: 2] = pdm;
                end
            end
        end else if (ld == LD_SINGLE) begin
            for (int i = 0; i < NCH; i++) begin
                // Only the selected channel moves
                if (sel == 2'(i)) begin
                    if (!pdf) begin
                        n.code[i] = code;
                        n.pd[i] = 1'b0;
                        n.pdm[2*i +: 2] = PDM_RUN;
                    end else if (pdm != PDM_RUN) begin
                        n.pd[i] = 1'b1;
                        n.pdm[2*i +: 2] = pdm;
                    end
                end
            end
        end
        n.cmd_cnt = s.cmd_cnt + 8'h01;
        n.last_cmd = w;
        return n;
    endfunction : apply_cmd

    function automatic logic [31:0] read_reg(input qdr_state_type s,
                                             input logic [ADDR_W-1:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        case (a)
            OFF_CTRL: d[CTRL_LINK_EN_BIT] = s.link_en;
            OFF_STATUS: begin
                d[ST_REF_ON_BIT] = s.ref_on;
                d[ST_MODE_LO +: 3] = s.mode;
                d[ST_PD_LO +: NCH] = s.pd;
                d[ST_CNT_LO +: 8] = s.cmd_cnt;
                d[ST_PDM_LO +: 2*NCH] = s.pdm;
            end
            OFF_CODE_AB: begin
                d[CODE_W-1:0] = s.code[0];
                d[CODE_HI_LO +: CODE_W] = s.code[1];
            end
            OFF_CODE_CD: begin
                d[CODE_W-1:0] = s.code[2];
                d[CODE_HI_LO +: CODE_W] = s.code[3];
            end
            OFF_LAST: d[CMD_W-1:0] = s.last_cmd;
            default: d = 32'h0000_0000;
        endcase
        return d;
    endfunction : read_reg

    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        logic ok;
        case (a)
            OFF_CTRL, OFF_STATUS, OFF_CODE_AB, OFF_CODE_CD, OFF_CMD, OFF_LAST: ok = 1'b1;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction : addr_ok

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        // Two-flop crossing of the frame toggle; word is stable long after it
        s_nxt.tgl_sync = {s_r.tgl_sync[SYNC_STAGES-2:0], lnk.tgl};
        s_nxt.tgl_seen = s_r.tgl_sync[SYNC_STAGES-1];
        if (s_r.tgl_sync[SYNC_STAGES-1] != s_r.tgl_seen && s_r.link_en) begin
            // All channels land in one clock, so they update together
            s_nxt = apply_cmd(s_nxt, lnk.word);
        end

        // APB: answer prepared in setup, completed in the access cycle
        if (psel && !penable) begin
            s_nxt.pready = 1'b1;
            s_nxt.pslverr = ~addr_ok(paddr);
            s_nxt.prdata = pwrite ? 32'h0000_0000 : read_reg(s_r, paddr);
        end else if (psel && penable && s_r.pready) begin
            s_nxt.pready = 1'b0;
            s_nxt.pslverr = 1'b0;
            if (pwrite) begin
                case (paddr)
                    OFF_CTRL: s_nxt.link_en = pwdata[CTRL_LINK_EN_BIT];
                    OFF_CMD: s_nxt = apply_cmd(s_nxt, pwdata[CMD_W-1:0]);
                    default: s_nxt.link_en = s_nxt.link_en;
                endcase
            end
        end else begin
            s_nxt.pready = 1'b0;
            s_nxt.pslverr = 1'b0;
        end

        // Reference power follows mode and channel states
        case (s_nxt.mode)
            REF_ON: s_nxt.ref_on = 1'b1;
            REF_OFF: s_nxt.ref_on = 1'b0;
            REF_AUTO: s_nxt.ref_on = ~&s_nxt.pd;
            default: s_nxt.ref_on = 1'b0;
        endcase
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_r.tgl_sync <= '0;
            s_r.tgl_seen <= 1'b0;
            s_r.mode <= REF_AUTO;
            s_r.code <= {NCH{CODE_RST}};
            s_r.pd <= PD_RST;
            s_r.pdm <= PDM_RST;
            s_r.ref_on <= 1'b0;
            s_r.link_en <= LINK_EN_RST;
            s_r.cmd_cnt <= 8'h00;
            s_r.last_cmd <= 24'h000000;
            s_r.prdata <= 32'h0000_0000;
            s_r.pready <= 1'b0;
            s_r.pslverr <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign chan_code = s_r.code;
    assign chan_pd = s_r.pd;
    assign chan_pd_mode = s_r.pdm;
    assign ref_on = s_r.ref_on;
    assign ref_mode = s_r.mode;

endmodule : qdr_ctrl

// File: rtl/qdr_pkg.sv
// Package: constants and types of the quad converter reference/broadcast control
package qdr_pkg;

    // ---------------------------------------------------------------
    // Command word layout
    // ---------------------------------------------------------------
    localparam int CMD_W = 24;
    localparam int CODE_W = 14;
    localparam int NCH = 4;
    localparam logic [4:0] BIT_LAST = 5'h17;
    localparam int LDH_BIT = 21;
    localparam int LDL_BIT = 20;
    localparam int SEL_HI = 18;
    localparam int SEL_LO = 17;
    localparam int PDF_BIT = 16;
    localparam int CODE_HI = 15;
    localparam int CODE_LO = 2;
    localparam int REF_HI = 15;
    localparam int REF_LO = 12;
    localparam int PDM_HI = 15;
    localparam int PDM_LO = 14;

    // ---------------------------------------------------------------
    // Command codes
    // ---------------------------------------------------------------
    localparam logic [1:0] LD_NONE = 2'h0;
    localparam logic [1:0] LD_SINGLE = 2'h1;
    localparam logic [1:0] LD_BCAST = 2'h3;
    localparam logic [1:0] SEL_BCAST = 2'h2;
    localparam logic [1:0] SEL_NONE = 2'h0;
    localparam logic [3:0] REF_CMD_AUTO = 4'h0;
    localparam logic [3:0] REF_CMD_ON = 4'h1;
    localparam logic [3:0] REF_CMD_OFF = 4'h2;
    localparam logic [1:0] PDM_RUN = 2'h0;
    localparam logic [1:0] PDM_HIZ = 2'h3;

    typedef enum logic [2:0] {
        REF_AUTO = 3'b001,
        REF_ON = 3'b010,
        REF_OFF = 3'b100
    } qdr_ref_mode_type;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [CODE_W-1:0] CODE_RST = 14'h0000;
    localparam logic [NCH-1:0] PD_RST = 4'hF;
    localparam logic [2*NCH-1:0] PDM_RST = 8'hFF;
    localparam logic LINK_EN_RST = 1'b1;

    // ---------------------------------------------------------------
    // APB register map
    // ---------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_CODE_AB = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_CODE_CD = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_CMD = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_LAST = 8'h14;
    localparam int CTRL_LINK_EN_BIT = 0;
    localparam int ST_REF_ON_BIT = 0;
    localparam int ST_MODE_LO = 1;
    localparam int ST_PD_LO = 4;
    localparam int ST_CNT_LO = 8;
    localparam int ST_PDM_LO = 16;
    localparam int CODE_HI_LO = 16;

endpackage : qdr_pkg

// File: rtl/qdr_link_if.sv
// Interface: received command words passed from the link domain to the core
`timescale 1ns/10ps
interface qdr_link_if;
    logic [23:0] word;
    logic tgl;

    modport rx (output word, output tgl);
    modport core (input word, input tgl);
endinterface : qdr_link_if

// File: rtl/qdr_serial_rx.sv
// Serial receiver on the link clock: collects 24-bit command frames
`timescale 1ns/10ps
module qdr_serial_rx
    import qdr_pkg::*;
(
    // Link pins
    input wire logic sclk,
    input wire logic rst_b,
    input wire logic sync_b,
    input wire logic din,
    // Word to core
    qdr_link_if.rx lnk
);

    typedef struct packed {
        logic [CMD_W-2:0] shift;
        logic [4:0] cnt;
        logic [CMD_W-1:0] word;
        logic tgl;
    } qdr_rx_state_type;

    qdr_rx_state_type s_r;
    qdr_rx_state_type s_nxt;

    // ---------------------------------------------------------------
    // Shift on falling edge, MSB first
    // ---------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        if (sync_b) begin
            s_nxt.cnt = 5'h00;
        end else if (s_r.cnt == BIT_LAST) begin
            // Word held until the next full frame: core reads it stable
            s_nxt.word = {s_r.shift, din};
            s_nxt.tgl = ~s_r.tgl;
            s_nxt.cnt = 5'h00;
        end else begin
            s_nxt.shift = {s_r.shift[CMD_W-3:0], din};
            s_nxt.cnt = s_r.cnt + 5'h01;
        end
    end

    always_ff @(negedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign lnk.word = s_r.word;
    assign lnk.tgl = s_r.tgl;

endmodule : qdr_serial_rx

// File: sim/qdr_ctrl_chk.sv
// Checker: port-level assertions of the reference and broadcast control
`timescale 1ns/10ps
module qdr_ctrl_chk
    import qdr_pkg::*;
(
    // System
    input wire logic clk,
    input wire logic rst_b,
    // Link and bus
    input wire logic sync_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Converter controls
    input wire logic [NCH-1:0][CODE_W-1:0] chan_code,
    input wire logic [NCH-1:0] chan_pd,
    input wire logic [2*NCH-1:0] chan_pd_mode,
    input wire logic ref_on,
    input wire logic [2:0] ref_mode
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_rst;
        $rose(rst_b) |-> ref_mode == REF_AUTO && chan_pd == PD_RST;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    // Two-cycle windows tolerate a one-cycle lag of ref_on
    property p_off;
        ref_mode == REF_OFF ##1 ref_mode == REF_OFF |-> !ref_on;
    endproperty
    a_off: assert property (p_off) else $error("reference on while forced off");
    property p_on;
        ref_mode == REF_ON ##1 ref_mode == REF_ON |-> ref_on;
    endproperty
    a_on: assert property (p_on) else $error("reference off while forced on");
    property p_adn;
        (ref_mode == REF_AUTO && chan_pd == 4'hF) [*2] |-> !ref_on;
    endproperty
    a_adn: assert property (p_adn) else $error("auto reference not off");
    property p_aup;
        (ref_mode == REF_AUTO && chan_pd != 4'hF) [*2] |-> ref_on;
    endproperty
    a_aup: assert property (p_aup) else $error("auto reference not on");
    property p_frm;
        !sync_b [*2] |-> $stable(chan_pd) && $stable(chan_code) && $stable(ref_mode);
    endproperty
    a_frm: assert property (p_frm) else $error("outputs moved mid-frame");
    property p_bc;
        $changed(chan_code[1]) && $changed(chan_code[2])
            |-> $changed(chan_code[0]) && $changed(chan_code[3]);
    endproperty
    a_bc: assert property (p_bc) else $error("broadcast codes not together");
    property p_pda;
        !chan_pd[0] |-> chan_pd_mode[1:0] == PDM_RUN;
    endproperty
    a_pda: assert property (p_pda) else $error("channel A up but mode not run");
    property p_sgl;
        $fell(chan_pd[0]) && $stable(chan_code[1]) |-> $stable(chan_pd[3:1]);
    endproperty
    a_sgl: assert property (p_sgl) else $error("single load moved others");
    property p_rdy;
        psel && !penable |=> pready ##1 !pready;
    endproperty
    a_rdy: assert property (p_rdy) else $error("ready not one cycle after setup");
    property p_err;
        pslverr |-> pready;
    endproperty
    a_err: assert property (p_err) else $error("error without ready");

    c_off: cover property (ref_mode == REF_OFF && chan_pd == 4'h0);
    c_hiz: cover property (ref_mode == REF_ON && chan_pd_mode == PDM_RST);
    c_err: cover property (pslverr);
endmodule : qdr_ctrl_chk

bind qdr_ctrl qdr_ctrl_chk i_chk (.clk(clk), .rst_b(rst_b), .sync_b(sync_b), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .chan_code(chan_code),
    .chan_pd(chan_pd), .chan_pd_mode(chan_pd_mode), .ref_on(ref_on), .ref_mode(ref_mode));

// File: sim/qdr_host_mdl.sv
// Host model: shifts 24-bit command frames into the link pins
`timescale 1ns/10ps
module qdr_host_mdl (
    // Link pins
    output logic sclk,
    output logic sync_b,
    output logic din
);
    // Clock stands high between frames
    initial begin
        sclk = 1'b1;
        sync_b = 1'b1;
        din = 1'b0;
    end

    task automatic send(input logic [23:0] w);
        #37;
        sync_b = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            din = w[i];
            #80 sclk = 1'b0;
            #80 sclk = 1'b1;
        end
        sync_b = 1'b1;
        // Released line shows the inverse, never a held value
        din = ~din;
        // Gap outlasts the crossing so frames never overlap an update
        #640;
    endtask : send
endmodule : qdr_host_mdl

// File: sim/qdr_ctrl_tb_top.sv
// Testbench: serial commands and register accesses against the control block
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; \
    $display("[ERR] %0t %h %h", $time, a, b); end end
module qdr_ctrl_tb_top
    import qdr_pkg::*;
;
    logic clk, rst_b, sclk, sync_b, din, psel, penable, pwrite, pready, pslverr, ref_on, err;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [NCH-1:0][CODE_W-1:0] chan_code;
    logic [NCH-1:0] chan_pd;
    logic [2*NCH-1:0] chan_pd_mode;
    logic [2:0] ref_mode;
    int mismatches, comparisons;
    localparam logic [23:0] HIZ = {4'h3, 4'h5, 2'h3, 14'h0000};

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    qdr_ctrl i_dut (.clk(clk), .rst_b(rst_b), .sclk(sclk), .sync_b(sync_b), .din(din),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .chan_code(chan_code),
        .chan_pd(chan_pd), .chan_pd_mode(chan_pd_mode), .ref_on(ref_on), .ref_mode(ref_mode));
    qdr_host_mdl i_host (.sclk(sclk), .sync_b(sync_b), .din(din));

    // ---------------------------------------------------------------
    // Access tasks
    // ---------------------------------------------------------------
    // Read right after the edge: outputs still hold their pre-edge values
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic [23:0] bc(input logic [13:0] c);
        return {4'h3, 4'h4, c, 2'h3};
    endfunction : bc

    function automatic logic [23:0] rf(input logic [3:0] r);
        return {4'h0, 4'h1, r, 12'h000};
    endfunction : rf

    task automatic st(input logic [2:0] m, input logic on, input logic [3:0] pd);
        `CHK(ref_mode, m)
        `CHK(ref_on, on)
        `CHK(chan_pd, pd)
    endtask : st

    task automatic test_done;
        if (mismatches == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done

    // ---------------------------------------------------------------
    // Sequence
    // ---------------------------------------------------------------
    initial begin
        {rst_b, psel, penable, pwrite, paddr, pwdata} <= '0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        st(REF_AUTO, 1'b0, 4'hF);
        apb(1'b0, OFF_STATUS, 32'h0);
        `CHK(rd, 32'h00FF_00F2)
        apb(1'b0, 8'h18, 32'h0);
        `CHK({err, rd}, 33'h1_0000_0000)
        i_host.send(bc(14'h1ABC));
        st(REF_AUTO, 1'b1, 4'h0);
        for (int i = 0; i < NCH; i++) `CHK(chan_code[i], 14'h1ABC)
        i_host.send(HIZ);
        st(REF_AUTO, 1'b0, 4'hF);
        `CHK(chan_pd_mode, 8'hFF)
        i_host.send({4'h1, 4'h0, 14'h0123, 2'h0});
        st(REF_AUTO, 1'b1, 4'hE);
        `CHK(chan_code[0], 14'h0123)
        `CHK({chan_pd_mode, chan_code[3]}, {8'hFC, 14'h1ABC})
        i_host.send(rf(REF_CMD_OFF));
        st(REF_OFF, 1'b0, 4'hE);
        i_host.send(bc(14'h2D5A));
        st(REF_OFF, 1'b0, 4'h0);
        `CHK(chan_code[2], 14'h2D5A)
        apb(1'b0, OFF_CODE_CD, 32'h0);
        `CHK(rd, 32'h2D5A_2D5A)
        apb(1'b0, OFF_LAST, 32'h0);
        `CHK(rd, {8'h00, bc(14'h2D5A)})
        i_host.send(rf(REF_CMD_ON));
        i_host.send(HIZ);
        st(REF_ON, 1'b1, 4'hF);
        i_host.send(rf(REF_CMD_AUTO));
        st(REF_AUTO, 1'b0, 4'hF);
        apb(1'b1, OFF_CMD, {8'h00, bc(14'h0777)});
        repeat (2) @(negedge clk);
        st(REF_AUTO, 1'b1, 4'h0);
        apb(1'b1, OFF_CTRL, 32'h0);
        i_host.send(HIZ);
        st(REF_AUTO, 1'b1, 4'h0);
        apb(1'b1, OFF_CTRL, 32'h1);
        apb(1'b0, OFF_CTRL, 32'h0);
        `CHK(rd, 32'h1)
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        st(REF_AUTO, 1'b0, 4'hF);
        test_done();
    end

    initial begin
        #500000;
        mismatches++;
        test_done();
    end
endmodule : qdr_ctrl_tb_top
